// ---- common/timer8_regs.svh ----
`ifndef TIMER8_REGS_SVH
`define TIMER8_REGS_SVH
// register addresses on the plain register port
`define CTRL_A_ADDR 4'h0
`define CTRL_B_ADDR 4'h1
`define COUNT_ADDR 4'h2
`define CMP_A_ADDR 4'h3
`define CMP_B_ADDR 4'h4
`define FLAG_ADDR 4'h5
`define MASK_ADDR 4'h6
// control a: [7:6] out mode a, [5:4] out mode b, [1:0] waveform mode low
`define CTRLA_OMA_LSB 6
`define CTRLA_OMB_LSB 4
`define CTRLA_WGM_LSB 0
// control b: [3] waveform mode high, [2:0] clock select
`define CTRLB_WGM2_BIT 3
`define CTRLB_CS_LSB 0
// flag and mask bit positions
`define OVF_BIT 0
`define CMPA_BIT 1
`define CMPB_BIT 2
`define RESET_VAL 8'h00
`define BOTTOM_VAL 8'h00
`define MAX_VAL 8'hff
`endif

// ---- common/timer8_pkg.sv ----
package timer8_pkg;
  typedef enum logic [2:0] {
    WGM_NORMAL = 3'b000,
    WGM_PC_MAX = 3'b001,
    WGM_CTC = 3'b010,
    WGM_FAST_MAX = 3'b011,
    WGM_RSVD4 = 3'b100,
    WGM_PC_OCRA = 3'b101,
    WGM_RSVD6 = 3'b110,
    WGM_FAST_OCRA = 3'b111
  } wave_mode_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic max;
    logic bottom;
    logic top;
    logic down;
    logic tick;
  } cnt_state_t;
endpackage

// ---- src/timer8_wave_out.sv ----
`timescale 1ns/1ps
`include "timer8_regs.svh"
// one compare output unit: buffering, match, and waveform bit
module timer8_wave_out (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // software side
  input wire logic i_cmp_wr,
  input wire logic [7:0] i_cmp_wdata,
  input wire logic [1:0] i_out_mode,
  input wire timer8_pkg::wave_mode_t i_mode,
  // counter side
  input wire logic [7:0] i_count,
  input wire timer8_pkg::cnt_state_t i_cnt,
  input wire logic i_block,
  // results
  output logic [7:0] o_cmp_visible,
  output logic [7:0] o_cmp_active,
  output logic o_match,
  output logic o_wave
);
  import timer8_pkg::*;
  logic [7:0] active_reg;
  logic [7:0] buffer_reg;
  logic pwm;
  logic fast;
  logic wave_reg;

  assign pwm = (i_mode != WGM_NORMAL) && (i_mode != WGM_CTC);
  assign fast = (i_mode == WGM_FAST_MAX) || (i_mode == WGM_FAST_OCRA);
  assign o_match = (i_count == active_reg) && !i_block;
  assign o_cmp_active = active_reg;
  assign o_cmp_visible = pwm ? buffer_reg : active_reg;
  assign o_wave = wave_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      buffer_reg <= `RESET_VAL;
    end else if (i_cmp_wr) begin
      buffer_reg <= i_cmp_wdata;
    end
  end

  // fast pwm updates at bottom, phase correct at top
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      active_reg <= `RESET_VAL;
    end else if (!pwm && i_cmp_wr) begin
      active_reg <= i_cmp_wdata;
    end else if (pwm && i_cnt.tick && (fast ? i_cnt.bottom : i_cnt.top)) begin
      active_reg <= buffer_reg;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wave_reg <= 1'b0;
    end else if (i_cnt.tick) begin
      if (!pwm) begin
        if (o_match) begin
          case (i_out_mode)
            2'b01: wave_reg <= !wave_reg;
            2'b10: wave_reg <= 1'b0;
            2'b11: wave_reg <= 1'b1;
            default: wave_reg <= wave_reg;
          endcase
        end
      end else if (fast) begin
        // non-inverting: set at bottom, clear on match
        if (o_match && i_out_mode[1]) begin
          wave_reg <= i_out_mode[0];
        end else if (i_cnt.bottom && i_out_mode[1]) begin
          wave_reg <= !i_out_mode[0];
        end
      end else if (o_match && i_out_mode[1]) begin
        wave_reg <= i_out_mode[0] ^ i_cnt.down;
      end else if (i_cnt.max && i_out_mode[1] && i_count != active_reg) begin
        wave_reg <= i_out_mode[0];
      end
    end
  end
endmodule

// ---- src/timer8_counter_compare.sv ----
`timescale 1ns/1ps
`include "timer8_regs.svh"
// Function
// - count and compare registers, eight bit, read/write
// - clock select picks tick; zero stops
// - count accessible whether running or not
// - software count write beats counter update
// - bottom indication when count is zero
// - max indication when count is 0xff
// - top is 0xff or compare a
// - tick clears, increments or decrements count
// - three-bit waveform mode split across controls
// - overflow flag point depends on mode
// - continuous equality compare per unit
// - compare flag set one tick later
// - enabled flag interrupts; cleared on acknowledge
// - writing one clears a flag
// - flags shown ungated; each interrupt gated by mask
// - outputs follow match, mode, extremes
// - pwm modes buffer compare writes
// - normal and ctc write compare directly
// - buffer copied only at top/bottom
// - compare access goes to buffer when buffered
// - normal mode wraps, overflow at zero
// - ctc clears on compare a match
// - count write blocks next tick match
module timer8_counter_compare #(
  parameter int PRESCALE_W = 10
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // register port
  input wire timer8_pkg::reg_req_t i_req,
  output logic [7:0] o_rdata,
  // external count pin
  input wire logic i_external_count_pin,
  // interrupt requests and acknowledges, bit order ovf, cmp a, cmp b
  output logic [2:0] o_irq,
  input wire logic [2:0] i_irq_ack,
  // waveform outputs
  output logic o_wave_out_a,
  output logic o_wave_out_b
);
  import timer8_pkg::*;
  logic [7:0] timer_control_a_reg;
  logic [7:0] timer_control_b_reg;
  logic [7:0] count_value_reg;
  logic [7:0] count_value_next;
  logic [2:0] timer_flag_reg;
  logic [2:0] timer_mask_reg;
  logic [7:0] o_rdata_reg;
  logic [PRESCALE_W-1:0] prescale_reg;
  logic [PRESCALE_W-1:0] prescale_prev_reg;
  logic ext_prev_reg;
  logic down_reg;
  logic block_reg;
  logic match_a_reg;
  logic match_b_reg;
  logic timer_tick;
  logic [2:0] clock_select_field;
  wave_mode_t waveform_mode_field;
  logic [7:0] top_val;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic match_a;
  logic match_b;
  logic pwm_pc;
  logic [7:0] compare_a_value;
  logic [7:0] compare_b_value;
  logic [7:0] cmp_a_active;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  cnt_state_t cnt;

  assign wr_count = i_req.wr && (i_req.addr == `COUNT_ADDR);
  assign wr_cmp_a = i_req.wr && (i_req.addr == `CMP_A_ADDR);
  assign wr_cmp_b = i_req.wr && (i_req.addr == `CMP_B_ADDR);
  assign clock_select_field = timer_control_b_reg[`CTRLB_CS_LSB +: 3];
  assign waveform_mode_field = wave_mode_t'({timer_control_b_reg[`CTRLB_WGM2_BIT],
    timer_control_a_reg[`CTRLA_WGM_LSB +: 2]});
  assign pwm_pc = (waveform_mode_field == WGM_PC_MAX) ||
    (waveform_mode_field == WGM_PC_OCRA);
  // top is compare a in ctc and the ocra pwm modes
  assign top_val = (waveform_mode_field == WGM_CTC || waveform_mode_field == WGM_PC_OCRA ||
    waveform_mode_field == WGM_FAST_OCRA) ? cmp_a_active : `MAX_VAL;

  // prescaler free runs; taps at 1, 8, 64, 256, 1024
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      prescale_reg <= '0;
      prescale_prev_reg <= '0;
      ext_prev_reg <= 1'b0;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
      prescale_prev_reg <= prescale_reg;
      ext_prev_reg <= i_external_count_pin;
    end
  end

  always_comb begin
    case (clock_select_field)
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = prescale_prev_reg[2] && !prescale_reg[2];
      3'h3: timer_tick = prescale_prev_reg[5] && !prescale_reg[5];
      3'h4: timer_tick = prescale_prev_reg[7] && !prescale_reg[7];
      3'h5: timer_tick = prescale_prev_reg[9] && !prescale_reg[9];
      3'h6: timer_tick = ext_prev_reg && !i_external_count_pin;
      3'h7: timer_tick = !ext_prev_reg && i_external_count_pin;
      default: timer_tick = 1'b0;
    endcase
  end

  assign cnt.tick = timer_tick;
  assign cnt.bottom = (count_value_reg == `BOTTOM_VAL);
  assign cnt.max = (count_value_reg == `MAX_VAL);
  assign cnt.top = (count_value_reg == top_val);
  assign cnt.down = down_reg;

  always_comb begin
    count_value_next = count_value_reg;
    if (pwm_pc) begin
      if (down_reg && !cnt.bottom) begin
        count_value_next = count_value_reg - 8'h01;
      end else if (!down_reg && !cnt.top) begin
        count_value_next = count_value_reg + 8'h01;
      end else if (cnt.top) begin
        count_value_next = count_value_reg - 8'h01;
      end else begin
        count_value_next = count_value_reg + 8'h01;
      end
    end else if (waveform_mode_field != WGM_NORMAL && cnt.top) begin
      count_value_next = `BOTTOM_VAL;
    end else begin
      count_value_next = count_value_reg + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      count_value_reg <= `RESET_VAL;
    end else if (wr_count) begin
      count_value_reg <= i_req.wdata;
    end else if (timer_tick) begin
      count_value_reg <= count_value_next;
    end
  end

  // phase correct direction turns at top and bottom
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !pwm_pc) begin
      down_reg <= 1'b0;
    end else if (timer_tick && cnt.top) begin
      down_reg <= 1'b1;
    end else if (timer_tick && cnt.bottom) begin
      down_reg <= 1'b0;
    end
  end

  // block lasts until the next tick, even while stopped
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      timer_control_a_reg <= `RESET_VAL;
      timer_control_b_reg <= `RESET_VAL;
      timer_mask_reg <= 3'h0;
    end else if (i_req.wr) begin
      case (i_req.addr)
        `CTRL_A_ADDR: timer_control_a_reg <= i_req.wdata;
        `CTRL_B_ADDR: timer_control_b_reg <= i_req.wdata & 8'h0f;
        `MASK_ADDR: timer_mask_reg <= i_req.wdata[2:0];
        default: timer_mask_reg <= timer_mask_reg;
      endcase
    end
  end

  // a match is latched and flagged at the following tick
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      match_a_reg <= 1'b0;
      match_b_reg <= 1'b0;
    end else if (timer_tick) begin
      match_a_reg <= match_a;
      match_b_reg <= match_b;
    end
  end

  always_comb begin
    flag_set = 3'h0;
    if (timer_tick) begin
      case (waveform_mode_field)
        WGM_NORMAL, WGM_CTC: flag_set[`OVF_BIT] = cnt.max;
        WGM_PC_MAX, WGM_PC_OCRA: flag_set[`OVF_BIT] = cnt.bottom && down_reg;
        default: flag_set[`OVF_BIT] = cnt.top;
      endcase
      flag_set[`CMPA_BIT] = match_a_reg;
      flag_set[`CMPB_BIT] = match_b_reg;
    end
  end

  assign flag_clr = i_irq_ack |
    ((i_req.wr && i_req.addr == `FLAG_ADDR) ? i_req.wdata[2:0] : 3'h0);

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      timer_flag_reg <= 3'h0;
    end else begin
      timer_flag_reg <= (timer_flag_reg & ~flag_clr) | flag_set;
    end
  end

  assign o_irq = timer_flag_reg & timer_mask_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata_reg <= 8'h00;
    end else if (i_req.rd) begin
      case (i_req.addr)
        `CTRL_A_ADDR: o_rdata_reg <= timer_control_a_reg;
        `CTRL_B_ADDR: o_rdata_reg <= timer_control_b_reg;
        `COUNT_ADDR: o_rdata_reg <= count_value_reg;
        `CMP_A_ADDR: o_rdata_reg <= compare_a_value;
        `CMP_B_ADDR: o_rdata_reg <= compare_b_value;
        `FLAG_ADDR: o_rdata_reg <= {5'h00, timer_flag_reg};
        `MASK_ADDR: o_rdata_reg <= {5'h00, timer_mask_reg};
        default: o_rdata_reg <= 8'h00;
      endcase
    end else begin
      o_rdata_reg <= 8'h00;
    end
  end
  assign o_rdata = o_rdata_reg;

  timer8_wave_out unit_a (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_cmp_wr(wr_cmp_a),
    .i_cmp_wdata(i_req.wdata),
    .i_out_mode(timer_control_a_reg[`CTRLA_OMA_LSB +: 2]),
    .i_mode(waveform_mode_field),
    .i_count(count_value_reg),
    .i_cnt(cnt),
    .i_block(block_reg),
    .o_cmp_visible(compare_a_value),
    .o_cmp_active(cmp_a_active),
    .o_match(match_a),
    .o_wave(o_wave_out_a)
  );

  timer8_wave_out unit_b (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_cmp_wr(wr_cmp_b),
    .i_cmp_wdata(i_req.wdata),
    .i_out_mode(timer_control_a_reg[`CTRLA_OMB_LSB +: 2]),
    .i_mode(waveform_mode_field),
    .i_count(count_value_reg),
    .i_cnt(cnt),
    .i_block(block_reg),
    .o_cmp_visible(compare_b_value),
    .o_cmp_active(),
    .o_match(match_b),
    .o_wave(o_wave_out_b)
  );

  stop_holds_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (clock_select_field == 3'h0 && !wr_count) |=> $stable(count_value_reg))
    else $error("count moved while stopped");
  write_wins_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_count |=> count_value_reg == $past(i_req.wdata))
    else $error("count write lost");
  normal_inc_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (timer_tick && !wr_count && waveform_mode_field == WGM_NORMAL)
    |=> count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("normal mode count wrong");
  ctc_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (timer_tick && !wr_count && waveform_mode_field == WGM_CTC && cnt.top)
    |=> count_value_reg == 8'h00)
    else $error("ctc did not clear");
  ovf_normal_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (timer_tick && !wr_count && waveform_mode_field == WGM_NORMAL && cnt.max)
    |=> count_value_reg == 8'h00 && timer_flag_reg[`OVF_BIT])
    else $error("overflow flag missing");
  // the latched match is what the following tick turns into the flag
  flag_late_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (timer_tick && match_a_reg) |=> timer_flag_reg[`CMPA_BIT])
    else $error("compare a flag not set next tick");
  block_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_count |=> !match_a && !match_b)
    else $error("match not blocked after count write");
  clear_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_req.wr && i_req.addr == `FLAG_ADDR && i_req.wdata[`CMPB_BIT] &&
    !flag_set[`CMPB_BIT]) |=> !timer_flag_reg[`CMPB_BIT])
    else $error("flag write did not clear");
  irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_irq == (timer_flag_reg & timer_mask_reg))
    else $error("interrupt gating wrong");
  pwm_buffer_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (wr_cmp_a && waveform_mode_field != WGM_NORMAL && waveform_mode_field != WGM_CTC
    && !(timer_tick && (cnt.top || cnt.bottom))) |=> $stable(cmp_a_active))
    else $error("active compare written in pwm");
  cover_ctc_c: cover property (@(posedge i_clk_sys) waveform_mode_field == WGM_CTC && cnt.top
    && timer_tick);
  cover_ovf_c: cover property (@(posedge i_clk_sys) flag_set[`OVF_BIT]);
  cover_irq_c: cover property (@(posedge i_clk_sys) o_irq[`CMPA_BIT] ##1 i_irq_ack[`CMPA_BIT]);
endmodule

// ---- test/timer8_cpu_model.sv ----
`timescale 1ns/1ps
// cpu side of the register port: one-cycle strobes, never both at once
module timer8_cpu_model (
  // clock and read data
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  // requests
  output timer8_pkg::reg_req_t o_req,
  output logic [2:0] o_irq_ack
);
  import timer8_pkg::*;
  initial begin
    o_req = '0;
    o_irq_ack = 3'h0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    o_req.wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe, so take it at that cycle's end
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    o_req.rd <= 1'b0;
    @(posedge i_clk_sys);
    d = i_rdata;
  endtask
  task automatic clr_flags(input logic [7:0] bits);
    wr(4'h5, bits);
  endtask
  task automatic ack(input logic [2:0] bits);
    @(posedge i_clk_sys);
    o_irq_ack <= bits;
    @(posedge i_clk_sys);
    o_irq_ack <= 3'h0;
  endtask
endmodule

// ---- test/timer8_counter_compare_tb_top.sv ----
`timescale 1ns/1ps
`include "timer8_regs.svh"
module timer8_counter_compare_tb_top;
  import timer8_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  reg_req_t req;
  logic [7:0] rdata;
  logic ext_pin = 1'b0;
  logic [2:0] irq;
  logic [2:0] irq_ack;
  logic wave_a;
  logic wave_b;
  int err_count = 0;
  int n_tests = 0;
  int toggles = 0;

  always #2.5 clk_sys = ~clk_sys;
  always @(wave_a) toggles++;

  timer8_cpu_model cpu (.i_clk_sys(clk_sys), .i_rdata(rdata), .o_req(req), .o_irq_ack(irq_ack));
  timer8_counter_compare dut (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_req(req), .o_rdata(rdata),
    .i_external_count_pin(ext_pin), .o_irq(irq), .i_irq_ack(irq_ack),
    .o_wave_out_a(wave_a), .o_wave_out_b(wave_b));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rc(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu.rd(a, d);
    chk(what, exp, d);
  endtask
  task automatic run(input int n);
    cpu.wr(`CTRL_B_ADDR, 8'h01);
    repeat (n) @(posedge clk_sys);
    cpu.wr(`CTRL_B_ADDR, 8'h00);
  endtask
  // pulses slow enough for the late pin edge detector
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys) ext_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      rc("reset reg", a[3:0], 8'h00);
    end
    chk("reset waves", 8'h00, {6'h0, wave_a, wave_b});
    $display("test reset done");
  endtask

  task automatic t_regs();
    cpu.wr(`COUNT_ADDR, 8'ha5);
    cpu.wr(`CMP_A_ADDR, 8'h5a);
    cpu.wr(`CMP_B_ADDR, 8'hc3);
    cpu.wr(`MASK_ADDR, 8'h07);
    cpu.wr(4'h7, 8'hff);
    rc("count", `COUNT_ADDR, 8'ha5);
    rc("cmp a", `CMP_A_ADDR, 8'h5a);
    rc("cmp b", `CMP_B_ADDR, 8'hc3);
    rc("mask", `MASK_ADDR, 8'h07);
    rc("unmapped", 4'h7, 8'h00);
    cpu.wr(`CTRL_B_ADDR, 8'hf8);
    rc("ctrl b", `CTRL_B_ADDR, 8'h08);
    cpu.wr(`CTRL_B_ADDR, 8'h00);
    cpu.wr(`MASK_ADDR, 8'h00);
    $display("test registers done");
  endtask

  task automatic t_select();
    cpu.wr(`COUNT_ADDR, 8'h10);
    pulses(3);
    rc("stopped count", `COUNT_ADDR, 8'h10);
    cpu.wr(`CTRL_B_ADDR, 8'h07);
    pulses(3);
    rc("rising count", `COUNT_ADDR, 8'h13);
    cpu.wr(`CTRL_B_ADDR, 8'h06);
    pulses(2);
    rc("falling count", `COUNT_ADDR, 8'h15);
    cpu.wr(`CTRL_B_ADDR, 8'h00);
    $display("test clock select done");
  endtask

  task automatic t_overflow();
    logic [7:0] d;
    cpu.wr(`CTRL_A_ADDR, 8'h00);
    cpu.wr(`CMP_A_ADDR, 8'h80);
    cpu.wr(`CMP_B_ADDR, 8'h80);
    cpu.clr_flags(8'h07);
    cpu.wr(`COUNT_ADDR, 8'hf8);
    run(20);
    chk("masked irq", 8'h00, {5'h0, irq});
    cpu.rd(`FLAG_ADDR, d);
    chk("ovf flag", 8'h01, {5'h0, d[2:0]});
    cpu.rd(`COUNT_ADDR, d);
    chk("wrapped", 8'h01, {7'h0, d < 8'h20});
    cpu.wr(`MASK_ADDR, 8'h01);
    // mask lands on the write's own edge, so look one edge later
    @(posedge clk_sys);
    chk("ovf irq", 8'h01, {5'h0, irq});
    cpu.clr_flags(8'h01);
    rc("flag cleared", `FLAG_ADDR, 8'h00);
    cpu.wr(`COUNT_ADDR, 8'hf8);
    run(20);
    chk("ovf irq again", 8'h01, {5'h0, irq});
    cpu.ack(3'b001);
    rc("flag acked", `FLAG_ADDR, 8'h00);
    chk("irq gone", 8'h00, {5'h0, irq});
    cpu.wr(`MASK_ADDR, 8'h00);
    $display("test overflow done");
  endtask

  task automatic t_ctc();
    logic [7:0] d;
    int t0;
    cpu.wr(`CTRL_A_ADDR, 8'h42);
    cpu.wr(`CMP_A_ADDR, 8'h05);
    cpu.wr(`COUNT_ADDR, 8'h00);
    cpu.clr_flags(8'h07);
    rc("ctc cmp a direct", `CMP_A_ADDR, 8'h05);
    t0 = toggles;
    run(40);
    cpu.rd(`COUNT_ADDR, d);
    chk("ctc top", 8'h01, {7'h0, d <= 8'h05});
    cpu.rd(`FLAG_ADDR, d);
    chk("ctc flag a", 8'h02, {6'h0, d[1], 1'b0});
    chk("wave toggled", 8'h01, {7'h0, toggles > t0 + 3});
    $display("test ctc done");
  endtask

  task automatic t_block();
    logic [7:0] d;
    cpu.wr(`CTRL_A_ADDR, 8'h00);
    cpu.wr(`CMP_B_ADDR, 8'h20);
    cpu.wr(`COUNT_ADDR, 8'h20);
    cpu.clr_flags(8'h07);
    run(10);
    cpu.rd(`FLAG_ADDR, d);
    chk("blocked match", 8'h00, {5'h0, d[2], 2'h0});
    cpu.wr(`COUNT_ADDR, 8'h1e);
    run(10);
    cpu.rd(`FLAG_ADDR, d);
    chk("real match", 8'h04, {5'h0, d[2], 2'h0});
    $display("test match block done");
  endtask

  task automatic t_buffer();
    cpu.wr(`CTRL_A_ADDR, 8'h03);
    cpu.wr(`CMP_A_ADDR, 8'h40);
    rc("pwm buffer read", `CMP_A_ADDR, 8'h40);
    cpu.wr(`CTRL_A_ADDR, 8'h00);
    rc("active kept", `CMP_A_ADDR, 8'h05);
    cpu.wr(`CTRL_A_ADDR, 8'h03);
    cpu.wr(`COUNT_ADDR, 8'hf0);
    run(40);
    cpu.wr(`CTRL_A_ADDR, 8'h00);
    rc("copied at bottom", `CMP_A_ADDR, 8'h40);
    $display("test buffering done");
  endtask

  // eight ticks from 0xfc: up to 0xff, turn, then down to 0xfa
  task automatic t_phase();
    cpu.wr(`CTRL_A_ADDR, 8'h01);
    cpu.wr(`COUNT_ADDR, 8'hfc);
    run(6);
    rc("phase correct turn", `COUNT_ADDR, 8'hfa);
    $display("test phase correct done");
  endtask

  // 66 enabled cycles at one tick per 8; the prescaler phase decides 8 or 9
  task automatic t_prescale();
    logic [7:0] d;
    cpu.wr(`CTRL_A_ADDR, 8'h00);
    cpu.wr(`COUNT_ADDR, 8'h00);
    cpu.wr(`CTRL_B_ADDR, 8'h02);
    repeat (64) @(posedge clk_sys);
    cpu.wr(`CTRL_B_ADDR, 8'h00);
    cpu.rd(`COUNT_ADDR, d);
    chk("prescaled ticks", 8'h01, {7'h0, (d == 8'h08 || d == 8'h09)});
    $display("test prescaler done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run is about five hundred cycles; this is ample
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("[ERR] watchdog expected end seen hang");
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_select();
    t_overflow();
    t_ctc();
    t_block();
    t_buffer();
    t_phase();
    t_prescale();
    stop_test();
  end
endmodule
